// File: tvdc_pkg.sv
// constants shared by the video digitizer control block
package tvdc_pkg;
	localparam int DATA_W = 8;
	localparam int SEL_W = 3;
	localparam int REF_BITS = 6;
	localparam int REF_COUNT = 6;
	localparam int CODE_W = 10;
	localparam int PIX_W = 24;
	localparam int FIFO_DEPTH = 8;
	// register select values
	localparam logic [2:0] CONTROL_CONFIG_SEL = 3'h0;
	localparam logic [2:0] REF_FIRST_SEL = 3'h1;
	localparam logic [2:0] REF_LAST_SEL = 3'h6;
	localparam logic [2:0] RESERVED_SEL = 3'h7;
	// control_config field positions
	localparam int SOURCE_SEL_BIT = 7;
	localparam int SYNC_SEL_HI = 6;
	localparam int SYNC_SEL_LO = 4;
	localparam int PACK_HI = 3;
	localparam int PACK_LO = 2;
	localparam int SLICE_LEVEL_BIT = 0;
	localparam logic [7:0] CONTROL_CONFIG_RESET = 8'h00;
	localparam logic [7:0] REF_RESET = 8'h00;
	// sync source codes above the six video inputs
	localparam logic [2:0] SYNC_AUX_A = 3'h6;
	localparam logic [2:0] SYNC_AUX_B = 3'h7;
	// saturation limits of a converter
	localparam logic [7:0] CODE_MIN = 8'h00;
	localparam logic [7:0] CODE_MAX = 8'hff;
	typedef enum logic [1:0] {
		TVDC_PACK_24,
		TVDC_PACK_15,
		TVDC_PACK_8_TRUE,
		TVDC_PACK_8_PSEUDO
	} tvdc_pack_t;
	// timing: fastest sample clock against the system clock
	localparam int REF_CLK_HZ = 50000000;
	localparam int MAX_SAMPLE_HZ = 15000000;
	localparam int MIN_SAMPLE_CYCLES = REF_CLK_HZ / MAX_SAMPLE_HZ;
endpackage : tvdc_pkg

// File: tvdc_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module tvdc_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr;
	logic [AW:0] rdPtr;
	logic [AW:0] next_wrPtr;
	logic [AW:0] next_rdPtr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// honest full and empty from the occupancy
	always_comb begin
		count = wrPtr - rdPtr;
		inReady = (count != (AW+1)'(DEPTH));
		outValid = (count != '0);
		push = inValid && inReady;
		pop = outValid && outReady;
		next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
		next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
		outData = mem[rdPtr[AW-1:0]];
	end

	// pointers and storage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
		end
		if (push) begin
			mem[wrPtr[AW-1:0]] <= inData;
		end
	end
endmodule : tvdc_fifo
`default_nettype wire

// File: tvdc_control.sv
// control, register port and pixel output path of the triple video digitizer
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - host port: 8-bit data, read and write strobes low, 3-bit select
// - host access is unrelated to sample clocks; strobes synchronised here
// - select 000 reaches the control configuration register
// - each converter yields 8-bit unsigned code saturating at 00 and ff
// - red, green and blue each sample on their own sample clock
// - control bit chooses source a or b for every converter
// - four packing modes: 24, 15, 8 true-colour, 8 pseudo-colour
// - host picks sync source; detected composite sync output as logic
// - control: source bit 7, sync 6-4, packing 3-2, bit 0 slice level
// - selects 001-110 hold reference codes, top six bits used, 111 reserved
// - zeroing high at a channel edge freezes that channel's outputs
// - pixel lines float while output enable low-active input is high
module tvdc_control
	import tvdc_pkg::*;
#(
	parameter int FIFO_WORDS = tvdc_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// host register port
	input wire logic [tvdc_pkg::SEL_W-1:0] regSelect,
	input wire logic readStrobeN,
	input wire logic writeStrobeN,
	input wire logic [tvdc_pkg::DATA_W-1:0] hostDataIn,
	output logic [tvdc_pkg::DATA_W-1:0] hostDataOut,
	output logic hostDataOe,
	// converter sample clocks and raw results
	input wire logic redSampleClock,
	input wire logic greenSampleClock,
	input wire logic blueSampleClock,
	input wire logic signed [tvdc_pkg::CODE_W-1:0] redLevel,
	input wire logic signed [tvdc_pkg::CODE_W-1:0] greenLevel,
	input wire logic signed [tvdc_pkg::CODE_W-1:0] blueLevel,
	input wire logic zeroing,
	// analog control outputs
	output logic sourceSelectB,
	output logic [2:0] syncSelect,
	output logic syncSliceHigh,
	output logic [tvdc_pkg::REF_COUNT*tvdc_pkg::REF_BITS-1:0] refCurrentOutputs,
	// sync detection
	input wire logic [5:0] videoSyncDetN,
	input wire logic auxSyncAN,
	input wire logic auxSyncBN,
	output logic compositeSyncN,
	// pixel output
	input wire logic outputEnableN,
	input wire logic pixelReady,
	output logic [tvdc_pkg::PIX_W-1:0] pixelOut,
	output logic pixelOe,
	output logic pixelValid,
	output logic sampleOverrun
);
	import tvdc_pkg::*;

	// two strobes, select, data, three clocks, zeroing, enable, three levels, eight sync inputs
	localparam int NSYNC = 2 + SEL_W + DATA_W + 5 + 3 * CODE_W + 8;
	// first and second stages of every pin synchroniser
	logic [NSYNC-1:0] syncA;
	logic [NSYNC-1:0] syncB;
	logic [2:0] clkPrev;
	logic rdPrev;
	logic wrPrev;
	logic [2:0] latchedSel;
	logic [7:0] controlConfig;
	logic [7:0] refReg [REF_COUNT];
	logic [7:0] redSample;
	logic [7:0] greenSample;
	logic [7:0] blueSample;
	// next values
	logic [2:0] next_latchedSel;
	logic [7:0] next_controlConfig;
	logic [7:0] next_refReg [REF_COUNT];
	logic [7:0] next_redSample;
	logic [7:0] next_greenSample;
	logic [7:0] next_blueSample;
	logic [7:0] next_hostDataOut;
	logic next_overrun;
	logic [PIX_W-1:0] next_pixelOut;
	logic next_pixelValid;
	logic next_syncN;
	// synchronised views
	logic rdS;
	logic wrS;
	logic [2:0] selS;
	logic [7:0] dataS;
	logic [2:0] clkS;
	logic zeroS;
	logic oeNS;
	logic [7:0] syncInS;
	logic signed [CODE_W-1:0] redS;
	logic signed [CODE_W-1:0] greenS;
	logic signed [CODE_W-1:0] blueS;
	logic [2:0] edgeHit;
	logic rdFall;
	logic wrRise;
	logic [7:0] packR;
	logic [7:0] packG;
	logic [7:0] packB;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoPop;
	logic [PIX_W-1:0] fifoOutData;

	function automatic logic [7:0] tvdc_sat(input logic signed [CODE_W-1:0] lv);
		if (lv <= $signed({CODE_W{1'b0}})) begin
			return CODE_MIN;
		end else if (lv >= $signed({2'b00, CODE_MAX})) begin
			return CODE_MAX;
		end else begin
			return lv[7:0];
		end
	endfunction : tvdc_sat

	always_ff @(posedge ref_clk) begin
		syncA <= {readStrobeN, writeStrobeN, regSelect, hostDataIn, redSampleClock, greenSampleClock,
			blueSampleClock, zeroing, outputEnableN, redLevel, greenLevel, blueLevel,
			auxSyncBN, auxSyncAN, videoSyncDetN};
		syncB <= syncA;
	end

	// unpack synchronised pins
	assign {rdS, wrS, selS, dataS, clkS, zeroS, oeNS, redS, greenS, blueS, syncInS} = syncB;

	// per-channel edges; 15 MS/s is above three system clocks apart
	assign edgeHit = clkS & ~clkPrev;
	assign rdFall = rdPrev && !rdS;
	assign wrRise = !wrPrev && wrS;

	always_comb begin
		case (tvdc_pack_t'(controlConfig[PACK_HI:PACK_LO]))
			TVDC_PACK_24: begin
				packR = redSample;
				packG = greenSample;
				packB = blueSample;
			end
			TVDC_PACK_15: begin
				packR = {1'b0, redSample[7:3], greenSample[7:6]};
				packG = {greenSample[5:3], blueSample[7:3]};
				packB = 8'h00;
			end
			TVDC_PACK_8_TRUE: begin
				packR = {redSample[7:5], greenSample[7:5], blueSample[7:6]};
				packG = packR;
				packB = packR;
			end
			default: begin
				packR = greenSample;
				packG = greenSample;
				packB = greenSample;
			end
		endcase
	end

	// packed word enters the buffer on each green sample
	tvdc_fifo #(
		.WIDTH(PIX_W),
		.DEPTH(FIFO_WORDS)
	) pixelFifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.inValid(edgeHit[1] && !zeroS),
		.inReady(fifoInReady),
		.inData({packR, packG, packB}),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData)
	);

	assign fifoPop = fifoOutValid && (pixelReady || !pixelValid);

	// next values of registers, samples and outputs
	always_comb begin
		next_latchedSel = latchedSel;
		next_controlConfig = controlConfig;
		next_refReg = refReg;
		next_hostDataOut = hostDataOut;
		next_redSample = redSample;
		next_greenSample = greenSample;
		next_blueSample = blueSample;
		next_pixelOut = pixelOut;
		next_pixelValid = pixelValid && !pixelReady;
		next_overrun = sampleOverrun;
		// address taken as either strobe falls
		if ((rdFall) || (wrPrev && !wrS)) begin
			next_latchedSel = selS;
		end
		if (wrRise) begin
			if (latchedSel == CONTROL_CONFIG_SEL) begin
				next_controlConfig = dataS;
			end else if (latchedSel >= REF_FIRST_SEL && latchedSel <= REF_LAST_SEL) begin
				next_refReg[latchedSel - REF_FIRST_SEL] = dataS;
			end
		end
		// read returns stored value, 111 reads zero
		if (rdFall) begin
			if (selS == CONTROL_CONFIG_SEL) begin
				next_hostDataOut = controlConfig;
			end else if (selS == RESERVED_SEL) begin
				next_hostDataOut = 8'h00;
			end else begin
				next_hostDataOut = refReg[selS - REF_FIRST_SEL];
			end
		end
		if (edgeHit[2] && !zeroS) begin
			next_redSample = tvdc_sat(redS);
		end
		if (edgeHit[1] && !zeroS) begin
			next_greenSample = tvdc_sat(greenS);
		end
		if (edgeHit[0] && !zeroS) begin
			next_blueSample = tvdc_sat(blueS);
		end
		// full buffer: the sample is dropped and flagged until reset
		if (edgeHit[1] && !zeroS && !fifoInReady) begin
			next_overrun = 1'b1;
		end
		if (fifoPop) begin
			next_pixelOut = fifoOutData;
			next_pixelValid = 1'b1;
		end
		next_syncN = syncInS[syncSelect];
	end

	// register state
	always_ff @(posedge ref_clk) begin
		clkPrev <= clkS;
		rdPrev <= rdS;
		wrPrev <= wrS;
		redSample <= next_redSample;
		greenSample <= next_greenSample;
		blueSample <= next_blueSample;
		pixelOut <= next_pixelOut;
		pixelOe <= !oeNS;
		hostDataOe <= !rdS && rdPrev ? 1'b1 : (!rdS && hostDataOe);
		hostDataOut <= next_hostDataOut;
		compositeSyncN <= next_syncN;
		if (rst) begin
			latchedSel <= CONTROL_CONFIG_SEL;
			controlConfig <= CONTROL_CONFIG_RESET;
			for (int i = 0; i < REF_COUNT; i++) begin
				refReg[i] <= REF_RESET;
			end
			pixelValid <= 1'b0;
			sampleOverrun <= 1'b0;
		end else begin
			latchedSel <= next_latchedSel;
			controlConfig <= next_controlConfig;
			refReg <= next_refReg;
			pixelValid <= next_pixelValid;
			sampleOverrun <= next_overrun;
		end
	end

	always_ff @(posedge ref_clk) begin
		sourceSelectB <= controlConfig[SOURCE_SEL_BIT];
		syncSelect <= controlConfig[SYNC_SEL_HI:SYNC_SEL_LO];
		syncSliceHigh <= controlConfig[SLICE_LEVEL_BIT];
		for (int i = 0; i < REF_COUNT; i++) begin
			refCurrentOutputs[i*REF_BITS +: REF_BITS] <= refReg[i][7:2];
		end
	end
endmodule : tvdc_control
`default_nettype wire

// File: tvdc_control_props.sv
// port assertions for the digitizer control block
`timescale 1ns/10ps
`default_nettype none
module tvdc_control_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// host port
	input wire logic readStrobeN,
	input wire logic writeStrobeN,
	input wire logic hostDataOe,
	// control and sync
	input wire logic sourceSelectB,
	input wire logic [2:0] syncSelect,
	input wire logic [35:0] refCurrentOutputs,
	input wire logic auxSyncAN,
	input wire logic compositeSyncN,
	// pixel side
	input wire logic outputEnableN,
	input wire logic pixelReady,
	input wire logic [23:0] pixelOut,
	input wire logic pixelOe,
	input wire logic pixelValid,
	input wire logic sampleOverrun
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// host bus, control, sync and pixel relations
	property p_rd_ans; $rose(hostDataOe) |-> !$past(readStrobeN, 2); endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("bus driven without read");
	property p_rd_end; readStrobeN [*5] |=> !hostDataOe; endproperty
	a_rd_end: assert property (p_rd_end) else $error("bus held after read");
	property p_wr_float; !writeStrobeN [*5] |=> !hostDataOe; endproperty
	a_wr_float: assert property (p_wr_float) else $error("bus driven in write");
	property p_oe_on; !outputEnableN [*5] |=> pixelOe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("pixel lines not driven");
	property p_oe_off; outputEnableN [*5] |=> !pixelOe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("pixel lines not floated");
	property p_pix_hold; pixelValid && !pixelReady |=> pixelValid && $stable(pixelOut); endproperty
	a_pix_hold: assert property (p_pix_hold) else $error("pixel word lost");
	property p_reg_quiet; writeStrobeN [*8] |=> $stable({sourceSelectB, syncSelect, refCurrentOutputs}); endproperty
	a_reg_quiet: assert property (p_reg_quiet) else $error("register moved without write");
	property p_sync_aux; (syncSelect == 3'h6 && !auxSyncAN) [*5] |=> !compositeSyncN; endproperty
	a_sync_aux: assert property (p_sync_aux) else $error("aux sync not routed");
	// main scenarios reached
	c_read: cover property ($rose(hostDataOe));
	c_pixel: cover property (pixelValid && pixelReady);
	c_overrun: cover property ($rose(sampleOverrun));
endmodule : tvdc_control_props
bind tvdc_control tvdc_control_props u_props (.ref_clk, .rst, .readStrobeN, .writeStrobeN, .hostDataOe,
	.sourceSelectB, .syncSelect, .refCurrentOutputs, .auxSyncAN, .compositeSyncN, .outputEnableN,
	.pixelReady, .pixelOut, .pixelOe, .pixelValid, .sampleOverrun);
`default_nettype wire

// File: tvdc_host_model.sv
// host processor model for the register port
`timescale 1ns/10ps
`default_nettype none
module tvdc_host_model (
	// clock
	input wire logic ref_clk,
	// register port
	output logic [2:0] regSelect,
	output logic readStrobeN,
	output logic writeStrobeN,
	output logic [7:0] hostDataIn,
	input wire logic [7:0] hostDataOut,
	input wire logic hostDataOe
);
	logic [7:0] busLevel;
	// wire level from both drivers
	assign busLevel = hostDataOe ? hostDataOut : hostDataIn;
	// idle bus, strobes high
	initial begin
		regSelect = 3'h0;
		readStrobeN = 1'b1;
		writeStrobeN = 1'b1;
		hostDataIn = 8'h5a;
	end
	task automatic write(input logic [2:0] sel, input logic [7:0] d);
		@(posedge ref_clk);
		regSelect <= sel;
		hostDataIn <= d;
		writeStrobeN <= 1'b0;
		repeat (4) @(posedge ref_clk);
		writeStrobeN <= 1'b1;
		repeat (4) @(posedge ref_clk);
		hostDataIn <= ~d;
	endtask : write
	task automatic read(input logic [2:0] sel, output logic [7:0] d);
		@(posedge ref_clk);
		regSelect <= sel;
		readStrobeN <= 1'b0;
		repeat (6) @(posedge ref_clk);
		d = busLevel;
		readStrobeN <= 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask : read
endmodule : tvdc_host_model
`default_nettype wire

// File: tvdc_control_bench.sv
// self-checking bench for the digitizer control block
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tvdc_control_bench;
	import tvdc_pkg::*;
	logic ref_clk, rst, readStrobeN, writeStrobeN, hostDataOe, zeroing, auxSyncAN, auxSyncBN, compositeSyncN;
	logic redSampleClock, greenSampleClock, blueSampleClock, outputEnableN, pixelReady, pixelOe, pixelValid;
	logic sampleOverrun, sourceSelectB, syncSliceHigh;
	logic [2:0] regSelect, syncSelect;
	logic [7:0] hostDataIn, hostDataOut, rd, w, sy;
	logic signed [9:0] redLevel, greenLevel, blueLevel;
	logic [5:0] videoSyncDetN;
	logic [35:0] refCurrentOutputs;
	logic [23:0] pixelOut, expPix;
	logic [15:0] seed;
	int n_mismatch, n_tests, nAcc, a0;
	tvdc_control DUT (.ref_clk, .rst, .regSelect, .readStrobeN, .writeStrobeN, .hostDataIn, .hostDataOut,
		.hostDataOe, .redSampleClock, .greenSampleClock, .blueSampleClock, .redLevel, .greenLevel, .blueLevel,
		.zeroing, .sourceSelectB, .syncSelect, .syncSliceHigh, .refCurrentOutputs, .videoSyncDetN, .auxSyncAN,
		.auxSyncBN, .compositeSyncN, .outputEnableN, .pixelReady, .pixelOut, .pixelOe, .pixelValid, .sampleOverrun);
	tvdc_host_model host (.ref_clk, .regSelect, .readStrobeN, .writeStrobeN, .hostDataIn, .hostDataOut,
		.hostDataOe);
	// random source
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// converter saturation
	function automatic logic [7:0] sat(input logic signed [9:0] v);
		return v[9] ? 8'h00 : ((v[8] || v[7:0] == 8'hff) ? 8'hff : v[7:0]);
	endfunction : sat
	function automatic logic [23:0] pack(input logic [1:0] m, input logic [7:0] r, g, b);
		case (m)
			2'h0: return {r, g, b};
			2'h1: return {1'b0, r[7:3], g[7:3], b[7:3], 8'h00};
			2'h2: return {3{r[7:5], g[7:5], b[7:6]}};
			default: return {3{g}};
		endcase
	endfunction : pack
	// sample clock pulses, 4 ref cycles each
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			{redSampleClock, greenSampleClock, blueSampleClock} <= 3'h7;
			repeat (2) @(posedge ref_clk);
			{redSampleClock, greenSampleClock, blueSampleClock} <= 3'h0;
			@(posedge ref_clk);
		end
	endtask : pulse
	task automatic print_verdict;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// accepted pixel words
	always @(posedge ref_clk) begin
		if (pixelValid === 1'b1 && pixelReady) nAcc++;
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		$display("ERROR t=%0t timeout", $time);
		print_verdict();
	end
	initial begin
		{rst, outputEnableN, pixelReady, zeroing, auxSyncAN, auxSyncBN} = 6'h23;
		{redSampleClock, greenSampleClock, blueSampleClock, videoSyncDetN} = 9'h03f;
		{redLevel, greenLevel, blueLevel} = 30'h0;
		seed = 16'h30de;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		for (int s = 0; s < 8; s++) begin
			seed = lfsr(seed);
			w = seed[7:0] & ((s == 0) ? 8'hfd : 8'hfc);
			host.write(s[2:0], w);
			host.read(s[2:0], rd);
			`CHECK(rd, (s == 7) ? 8'h00 : w)
			if (s > 0 && s < 7) `CHECK(refCurrentOutputs[6*(s-1) +: 6], w[7:2])
		end
		$display("registers done");
		for (int s = 0; s < 8; s++) begin
			seed = lfsr(seed);
			{videoSyncDetN, auxSyncAN, auxSyncBN} <= {seed[7:2], (s == 6) ? 1'b0 : seed[1], seed[0]};
			host.write(3'h0, {seed[8], s[2:0], 3'h0, seed[9]});
			repeat (4) @(posedge ref_clk);
			sy = {auxSyncBN, auxSyncAN, videoSyncDetN};
			`CHECK({sourceSelectB, syncSelect, syncSliceHigh}, {seed[8], s[2:0], seed[9]})
			`CHECK(compositeSyncN, sy[s])
		end
		$display("sync done");
		pixelReady <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			seed = lfsr(seed);
			host.write(3'h0, {4'h0, m[1:0], 2'h0});
			{redLevel, greenLevel, blueLevel} <= (m < 4) ? {10'h3ff, 10'h0ff, 10'h12c} : {seed[9:0], seed[15:6], seed[12:3]};
			pulse(1);
			repeat (12) @(posedge ref_clk);
			pulse(1);
			for (int i = 0; i < 20 && pixelValid !== 1'b1; i++) @(negedge ref_clk);
			expPix = pack(m[1:0], sat(redLevel), sat(greenLevel), sat(blueLevel));
			`CHECK(pixelOut, expPix)
		end
		$display("packing done");
		repeat (12) @(posedge ref_clk);
		a0 = nAcc;
		zeroing <= 1'b1;
		{redLevel, greenLevel, blueLevel} <= ~{redLevel, greenLevel, blueLevel};
		repeat (4) @(posedge ref_clk);
		pulse(3);
		repeat (6) @(posedge ref_clk);
		`CHECK(nAcc, a0)
		zeroing <= 1'b0;
		repeat (4) @(posedge ref_clk);
		pulse(1);
		for (int i = 0; i < 20 && pixelValid !== 1'b1; i++) @(negedge ref_clk);
		`CHECK(pixelOut, expPix)
		$display("zeroing done");
		repeat (8) @(posedge ref_clk);
		pixelReady <= 1'b0;
		pulse(8);
		repeat (3) @(negedge ref_clk);
		`CHECK(sampleOverrun, 1'b0)
		pulse(3);
		repeat (3) @(negedge ref_clk);
		`CHECK(sampleOverrun, 1'b1)
		@(posedge ref_clk);
		a0 = nAcc;
		pixelReady <= 1'b1;
		repeat (40) @(negedge ref_clk);
		`CHECK(nAcc - a0, 9)
		// output enable drives and floats pixels
		@(posedge ref_clk);
		outputEnableN <= 1'b1;
		repeat (6) @(negedge ref_clk);
		`CHECK(pixelOe, 1'b0)
		@(posedge ref_clk);
		outputEnableN <= 1'b0;
		repeat (6) @(negedge ref_clk);
		`CHECK(pixelOe, 1'b1)
		$display("buffer done");
		print_verdict();
	end
endmodule : tvdc_control_bench
`default_nettype wire
